// [src/scseq_pkg.sv]
// Package: constants and types of the status condition and error queue block
package scseq_pkg;
  localparam int SCSEQ_NSETS = 5;
  localparam int SCSEQ_DW = 16;
  localparam int SCSEQ_QDEPTH = 10;
  localparam int SCSEQ_AW = 8;
  // Set order inside every per-set array
  localparam logic [2:0] SCSEQ_SET_OPER = 3'h0;
  localparam logic [2:0] SCSEQ_SET_TRIG = 3'h1;
  localparam logic [2:0] SCSEQ_SET_ARM = 3'h2;
  localparam logic [2:0] SCSEQ_SET_SEQ = 3'h3;
  localparam logic [2:0] SCSEQ_SET_QUES = 3'h4;
  localparam int SCSEQ_IDLE_BIT = 10;
  // Register word indices; byte address is four times the index
  localparam logic [4:0] SCSEQ_IDX_COND = 5'h00;
  localparam logic [4:0] SCSEQ_IDX_RISE = 5'h05;
  localparam logic [4:0] SCSEQ_IDX_FALL = 5'h0A;
  localparam logic [4:0] SCSEQ_IDX_ENAB = 5'h0F;
  localparam logic [4:0] SCSEQ_IDX_EVENT = 5'h14;
  localparam logic [4:0] SCSEQ_IDX_QUEUE = 5'h19;
  localparam logic [4:0] SCSEQ_IDX_SYSERR = 5'h1A;
  localparam logic [4:0] SCSEQ_IDX_CTRL = 5'h1B;
  localparam logic [4:0] SCSEQ_IDX_IRQ_ST = 5'h1C;
  localparam logic [4:0] SCSEQ_IDX_IRQ_MASK = 5'h1D;
  localparam logic [4:0] SCSEQ_IDX_QCOUNT = 5'h1E;
  // Control register fields
  localparam int SCSEQ_CTRL_PRESET = 0;
  localparam int SCSEQ_CTRL_CLS = 1;
  // Interrupt status fields; bits 0..4 are the per-set enabled events
  localparam int SCSEQ_IRQ_OVF = 5;
  localparam int SCSEQ_IRQ_MSG = 6;
  localparam int SCSEQ_IRQ_W = 7;
  // Message codes
  localparam logic signed [15:0] SCSEQ_MSG_NONE = 16'sh0000;
  localparam logic signed [15:0] SCSEQ_MSG_OVF = 16'sh015E;
  // Reset and preset patterns, bus response codes and queue limits
  localparam logic [15:0] SCSEQ_ONES = 16'hFFFF;
  localparam logic [15:0] SCSEQ_ZERO = 16'h0000;
  localparam logic [1:0] SCSEQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] SCSEQ_RESP_SLVERR = 2'h2;
  localparam logic [3:0] SCSEQ_QLAST = 4'h9;
  localparam logic [3:0] SCSEQ_QFULL = 4'hA;

  typedef logic [SCSEQ_NSETS-1:0][SCSEQ_DW-1:0] scseq_sets_t;

  typedef struct packed {
    logic valid;
    logic signed [15:0] code;
  } scseq_msg_t;

  typedef struct packed {
    logic awvalid;
    logic [SCSEQ_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [SCSEQ_AW-1:0] araddr;
    logic rready;
  } scseq_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scseq_axi_rsp_t;
endpackage

// [src/scseq_top.sv]
// Status condition registers, transition filters and error queue
// Functional notes
// RL1: Condition register per set, readable over the bus.
// RL2: Each set pairs its condition register with its event register.
// RL3: Condition registers follow live status every cycle, no latching.
// RL4: Condition bits feed rising and falling transition filters.
// RL5: Reads return the register value as a plain binary number.
// RL6: Operation condition bit 10 is high while idle.
// RL7: Preset sets all rising-edge filter bits to one.
// RL8: Preset clears all falling-edge filter bits.
// RL9: Preset clears operation and questionable enable registers.
// RL10: Preset sets trigger, arm and sequence enable registers to ones.
// RL11: Preset leaves condition, event registers and queue alone.
// RL12: Queue read returns oldest message and removes it.
// RL13: Queue holds ten messages.
// RL14: On filling, last slot holds overflow code 350.
// RL15: Empty queue read returns code 0.
// RL16: Messages carry signed codes, negative standard, positive maker.
// RL17: Queue empty at power-up and on clear status, not preset.
// RL18: Queue read and system error read pop the same queue.
// RL19: Condition reads have no side effects.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
module scseq_top (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Live instrument status
  input wire scseq_pkg::scseq_sets_t live_in,
  input wire logic idle_in,
  // Error message source
  input wire scseq_pkg::scseq_msg_t msg_in,
  // AXI4-Lite slave
  input wire scseq_pkg::scseq_axi_req_t axi_req_in,
  output scseq_pkg::scseq_axi_rsp_t axi_rsp_out,
  // Interrupt
  output logic irq_out
);
  import scseq_pkg::*;

  typedef struct packed {
    scseq_sets_t cond;
    scseq_sets_t rise;
    scseq_sets_t fall;
    scseq_sets_t enab;
    scseq_sets_t event_r;
    logic [SCSEQ_QDEPTH-1:0][15:0] q;
    logic [3:0] head;
    logic [3:0] cnt;
    logic [SCSEQ_IRQ_W-1:0] irq_st;
    logic [SCSEQ_IRQ_W-1:0] irq_mask;
    logic aw_got;
    logic [SCSEQ_AW-1:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scseq_state_t;

  scseq_state_t s_r;
  scseq_state_t s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;

  // Word index of a byte address, with a flag for a mapped word
  function automatic logic [5:0] decode(input logic [SCSEQ_AW-1:0] a);
    logic ok;
    ok = (a[SCSEQ_AW-1] == 1'b0) && (a[6:2] <= SCSEQ_IDX_QCOUNT);
    return {ok, a[6:2]};
  endfunction

  // Ring index step, wraps at queue depth
  function automatic logic [3:0] qstep(input logic [3:0] i,
                                       input logic [3:0] d);
    logic [4:0] t;
    t = {1'b0, i} + {1'b0, d};
    if (t >= 5'(SCSEQ_QDEPTH))
      t = t - 5'(SCSEQ_QDEPTH);
    return t[3:0];
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    logic [15:0] m;
    m = old;
    if (be[0])
      m[7:0] = d[7:0];
    if (be[1])
      m[15:8] = d[15:8];
    return m;
  endfunction

  // Reset released through two flops
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      rst_sync_r <= 2'b00;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_n = rst_sync_r[1];

  always_comb
  begin
    scseq_sets_t live;
    scseq_sets_t hit;
    logic [5:0] rd;
    logic [5:0] wr;
    logic [4:0] idx;
    logic [15:0] wv;
    logic [15:0] rv;
    logic pop;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic [3:0] tail;
    logic [SCSEQ_IRQ_W-1:0] irq_set;
    s_nxt = s_r;
    live = live_in;
    live[SCSEQ_SET_OPER][SCSEQ_IDLE_BIT] = idle_in; // RL6
    rv = SCSEQ_ZERO;
    pop = 1'b0;
    tail = 4'h0;
    idx = 5'h00;
    wv = SCSEQ_ZERO;
    hit = '0;
    rd = 6'h00;
    wr = 6'h00;
    aw_hs = 1'b0;
    w_hs = 1'b0;
    ar_hs = 1'b0;
    irq_set = '0;

    // Transition detection compares live status with the previous copy
    for (int i = 0; i < SCSEQ_NSETS; i++)
    begin
      hit[i] = (s_r.rise[i] & live[i] & ~s_r.cond[i])
             | (s_r.fall[i] & ~live[i] & s_r.cond[i]); // RL4
      s_nxt.event_r[i] = s_r.event_r[i] | hit[i]; // RL2
      irq_set[i] = |(hit[i] & s_r.enab[i]);
    end
    s_nxt.cond = live; // RL3 RL1

    // Bus handshakes
    // No handshake in reset or while frozen, else a transfer is lost
    axi_rsp_out.awready = rst_n && ce_in && !s_r.aw_got && !s_r.bvalid;
    axi_rsp_out.wready = rst_n && ce_in && !s_r.w_got && !s_r.bvalid;
    axi_rsp_out.arready = rst_n && ce_in && !s_r.rvalid;
    axi_rsp_out.bvalid = ce_in && s_r.bvalid;
    axi_rsp_out.bresp = s_r.bresp;
    axi_rsp_out.rvalid = ce_in && s_r.rvalid;
    axi_rsp_out.rdata = s_r.rdata;
    axi_rsp_out.rresp = s_r.rresp;
    aw_hs = axi_req_in.awvalid && axi_rsp_out.awready;
    w_hs = axi_req_in.wvalid && axi_rsp_out.wready;
    ar_hs = axi_req_in.arvalid && axi_rsp_out.arready;
    if (aw_hs)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = axi_req_in.awaddr;
    end
    if (w_hs)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = axi_req_in.wdata;
      s_nxt.wstrb = axi_req_in.wstrb;
    end
    if (s_r.bvalid && axi_req_in.bready)
      s_nxt.bvalid = 1'b0;
    if (s_r.rvalid && axi_req_in.rready)
      s_nxt.rvalid = 1'b0;

    // Read side; only the two queue words have a side effect
    rd = decode(axi_req_in.araddr);
    if (ar_hs)
    begin
      idx = rd[4:0];
      if (idx < SCSEQ_IDX_RISE)
        rv = s_r.cond[idx]; // RL1 RL19
      else if (idx < SCSEQ_IDX_FALL)
        rv = s_r.rise[idx - SCSEQ_IDX_RISE];
      else if (idx < SCSEQ_IDX_ENAB)
        rv = s_r.fall[idx - SCSEQ_IDX_FALL];
      else if (idx < SCSEQ_IDX_EVENT)
        rv = s_r.enab[idx - SCSEQ_IDX_ENAB];
      else if (idx < SCSEQ_IDX_QUEUE)
        rv = s_r.event_r[idx - SCSEQ_IDX_EVENT];
      else if (idx == SCSEQ_IDX_QUEUE || idx == SCSEQ_IDX_SYSERR)
      begin
        if (s_r.cnt != 4'h0)
        begin
          rv = s_r.q[s_r.head]; // RL12 RL18 RL16
          pop = rd[5];
        end
        else
          rv = SCSEQ_MSG_NONE; // RL15
      end
      else if (idx == SCSEQ_IDX_IRQ_ST)
        rv = 16'(s_r.irq_st);
      else if (idx == SCSEQ_IDX_IRQ_MASK)
        rv = 16'(s_r.irq_mask);
      else if (idx == SCSEQ_IDX_QCOUNT)
        rv = 16'(s_r.cnt);
      else
        rv = SCSEQ_ZERO;
      // Codes are sign-extended so software sees negative numbers
      s_nxt.rdata = {{16{rv[15]}}, rv}; // RL5
      if (idx < SCSEQ_IDX_QUEUE || idx > SCSEQ_IDX_SYSERR)
        s_nxt.rdata = {16'h0000, rv};
      if (!rd[5])
        s_nxt.rdata = 32'h0000_0000;
      s_nxt.rresp = rd[5] ? SCSEQ_RESP_OKAY : SCSEQ_RESP_SLVERR;
      s_nxt.rvalid = 1'b1;
    end

    // Queue pop, then clear status, then push
    if (pop)
    begin
      s_nxt.head = qstep(s_r.head, 4'h1); // RL12
      s_nxt.cnt = s_r.cnt - 4'h1;
    end

    // Write side runs once address and data are both held
    wr = decode(s_r.awaddr);
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr[5] ? SCSEQ_RESP_OKAY : SCSEQ_RESP_SLVERR;
      idx = wr[4:0];
      if (wr[5])
      begin
        if (idx >= SCSEQ_IDX_RISE && idx < SCSEQ_IDX_FALL)
          s_nxt.rise[idx - SCSEQ_IDX_RISE] =
            merge(s_r.rise[idx - SCSEQ_IDX_RISE], s_r.wdata, s_r.wstrb);
        else if (idx >= SCSEQ_IDX_FALL && idx < SCSEQ_IDX_ENAB)
          s_nxt.fall[idx - SCSEQ_IDX_FALL] =
            merge(s_r.fall[idx - SCSEQ_IDX_FALL], s_r.wdata, s_r.wstrb);
        else if (idx >= SCSEQ_IDX_ENAB && idx < SCSEQ_IDX_EVENT)
          s_nxt.enab[idx - SCSEQ_IDX_ENAB] =
            merge(s_r.enab[idx - SCSEQ_IDX_ENAB], s_r.wdata, s_r.wstrb);
        else if (idx >= SCSEQ_IDX_EVENT && idx < SCSEQ_IDX_QUEUE)
        begin
          // Write one to clear; a new event in the same cycle wins
          wv = merge(SCSEQ_ZERO, s_r.wdata, s_r.wstrb);
          s_nxt.event_r[idx - SCSEQ_IDX_EVENT] =
            (s_r.event_r[idx - SCSEQ_IDX_EVENT] & ~wv)
            | hit[idx - SCSEQ_IDX_EVENT];
        end
        else if (idx == SCSEQ_IDX_IRQ_ST && s_r.wstrb[0])
          s_nxt.irq_st = s_r.irq_st & ~s_r.wdata[SCSEQ_IRQ_W-1:0];
        else if (idx == SCSEQ_IDX_IRQ_MASK && s_r.wstrb[0])
          s_nxt.irq_mask = s_r.wdata[SCSEQ_IRQ_W-1:0];
        else if (idx == SCSEQ_IDX_CTRL && s_r.wstrb[0])
        begin
          if (s_r.wdata[SCSEQ_CTRL_PRESET])
          begin
            // Condition, event and queue state are untouched here
            for (int i = 0; i < SCSEQ_NSETS; i++)
            begin
              s_nxt.rise[i] = SCSEQ_ONES; // RL7 RL11
              s_nxt.fall[i] = SCSEQ_ZERO; // RL8
              s_nxt.enab[i] = SCSEQ_ONES; // RL10
            end
            s_nxt.enab[SCSEQ_SET_OPER] = SCSEQ_ZERO; // RL9
            s_nxt.enab[SCSEQ_SET_QUES] = SCSEQ_ZERO; // RL9
          end
          if (s_r.wdata[SCSEQ_CTRL_CLS])
          begin
            s_nxt.head = 4'h0; // RL17
            s_nxt.cnt = 4'h0; // RL17
          end
        end
      end
    end

    // Push; a message arriving with a full queue is dropped
    tail = qstep(s_nxt.head, s_nxt.cnt);
    if (msg_in.valid && s_nxt.cnt < SCSEQ_QFULL) // RL13
    begin
      s_nxt.cnt = s_nxt.cnt + 4'h1;
      irq_set[SCSEQ_IRQ_MSG] = 1'b1;
      if (s_nxt.cnt == SCSEQ_QFULL)
      begin
        s_nxt.q[tail] = SCSEQ_MSG_OVF; // RL14
        irq_set[SCSEQ_IRQ_OVF] = 1'b1;
      end
      else
        s_nxt.q[tail] = msg_in.code; // RL16
    end
    // A new interrupt event wins over a clear in the same cycle
    s_nxt.irq_st = s_nxt.irq_st | irq_set;
  end

  assign irq_out = |(s_r.irq_st & s_r.irq_mask);

  always_ff @(posedge ref_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      for (int i = 0; i < SCSEQ_NSETS; i++)
      begin
        s_r.rise[i] <= SCSEQ_ONES;
        s_r.enab[i] <= SCSEQ_ONES;
      end
      s_r.enab[SCSEQ_SET_OPER] <= SCSEQ_ZERO;
      s_r.enab[SCSEQ_SET_QUES] <= SCSEQ_ZERO;
    end
    else if (ce_in)
      s_r <= s_nxt;
  end
endmodule

// [verification/scseq_assertions.sv]
// Checker of bus timing and register reads of the status block
module scseq_assertions (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic ce_in,
  // Status and messages
  input wire scseq_pkg::scseq_sets_t live_in,
  input wire logic idle_in,
  input wire scseq_pkg::scseq_msg_t msg_in,
  // Bus and interrupt
  input wire scseq_pkg::scseq_axi_req_t axi_req_in,
  input wire scseq_pkg::scseq_axi_rsp_t axi_rsp_out,
  input wire logic irq_out
);
  import scseq_pkg::*;
  default clocking cb @(posedge ref_clk_in); endclocking
  // Frozen cycles are not judged: nothing may move then
  default disable iff (!arst_n_in || !ce_in);
  logic ar_go;
  logic aw_go;
  assign ar_go = axi_req_in.arvalid && axi_rsp_out.arready;
  assign aw_go = axi_req_in.awvalid && axi_rsp_out.awready &&
    axi_req_in.wvalid && axi_rsp_out.wready;
  rd_latency_a: assert property (ar_go |=> axi_rsp_out.rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (axi_rsp_out.rvalid && !axi_req_in.rready
    |=> axi_rsp_out.rvalid && $stable(axi_rsp_out.rdata))
    else $error("read data not held");
  ar_block_a: assert property (axi_rsp_out.rvalid |-> !axi_rsp_out.arready)
    else $error("read taken while answer pending");
  wr_latency_a: assert property (aw_go |-> ##[1:2] axi_rsp_out.bvalid)
    else $error("write answer late");
  wr_hold_a: assert property (axi_rsp_out.bvalid && !axi_req_in.bready
    |=> axi_rsp_out.bvalid && $stable(axi_rsp_out.bresp))
    else $error("write answer not held");
  aw_block_a: assert property (axi_rsp_out.bvalid
    |-> !axi_rsp_out.awready && !axi_rsp_out.wready)
    else $error("write taken while answer pending");
  idle_bit_a: assert property (ar_go && axi_req_in.araddr == 8'h00 &&
    idle_in && $past(idle_in) |=> axi_rsp_out.rdata[SCSEQ_IDLE_BIT])
    else $error("idle bit missing");
  cond_read_a: assert property (ar_go && axi_req_in.araddr == 8'h04 &&
    $stable(live_in[1]) |=> axi_rsp_out.rdata == {16'h0000, $past(live_in[1])})
    else $error("condition read differs from live status");
  bad_addr_a: assert property (ar_go && axi_req_in.araddr[7] |=>
    axi_rsp_out.rresp == SCSEQ_RESP_SLVERR && axi_rsp_out.rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule

bind scseq_top scseq_assertions i_scseq_assertions (
  .ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in),
  .live_in(live_in), .idle_in(idle_in), .msg_in(msg_in),
  .axi_req_in(axi_req_in), .axi_rsp_out(axi_rsp_out), .irq_out(irq_out));

// [verification/scseq_host.sv]
// Host side model: bus master that queries the status block
module scseq_host (
  // Clock
  input wire logic clk_in,
  // Bus
  input wire scseq_pkg::scseq_axi_rsp_t rsp_in,
  output scseq_pkg::scseq_axi_req_t req_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import scseq_pkg::*;
  initial req_out = '0;
  // Ready may start low for one cycle, but is high by the time any answer is valid
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] r, output bit to);
    int n;
    n = 0;
    @(posedge clk_in);
    req_out.awvalid <= 1'b1;
    req_out.awaddr <= a;
    req_out.wvalid <= 1'b1;
    req_out.wdata <= v;
    req_out.wstrb <= 4'hF;
    req_out.bready <= 1'($urandom);
    do
    begin
      @(posedge clk_in);
      n++;
      if (rsp_in.awready) req_out.awvalid <= 1'b0;
      if (rsp_in.wready) req_out.wvalid <= 1'b0;
      if (!req_out.bready) req_out.bready <= 1'b1;
    end while (!(rsp_in.bvalid && req_out.bready) && n < 50);
    r = rsp_in.bresp;
    req_out.bready <= 1'b0;
    to = (n >= 50);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r, output bit to);
    int n;
    n = 0;
    @(posedge clk_in);
    req_out.arvalid <= 1'b1;
    req_out.araddr <= a;
    req_out.rready <= 1'($urandom);
    do
    begin
      @(posedge clk_in);
      n++;
      if (rsp_in.arready) req_out.arvalid <= 1'b0;
      if (!req_out.rready) req_out.rready <= 1'b1;
    end while (!(rsp_in.rvalid && req_out.rready) && n < 50);
    d = rsp_in.rdata;
    r = rsp_in.rresp;
    req_out.rready <= 1'b0;
    to = (n >= 50);
  endtask
endmodule

// [verification/scseq_tb_top.sv]
// Testbench of the status condition and error queue block
module scseq_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import scseq_pkg::*;
`define CK(n, e, a) begin compares++; if ((a) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, a); end end
  logic ref_clk_in = 0;
  logic arst_n_in = 0;
  logic ce_in;
  scseq_sets_t live_in;
  logic idle_in;
  scseq_msg_t msg_in;
  scseq_axi_req_t req;
  scseq_axi_rsp_t rsp;
  logic irq_out;
  int err_total;
  int compares;
  logic [31:0] d;
  logic [1:0] r;
  bit to;
  logic signed [15:0] q[$];
  always #25 ref_clk_in = ~ref_clk_in;
  scseq_top i_scseq_top (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .ce_in(ce_in), .live_in(live_in), .idle_in(idle_in), .msg_in(msg_in),
    .axi_req_in(req), .axi_rsp_out(rsp), .irq_out(irq_out));
  scseq_host i_scseq_host (.clk_in(ref_clk_in), .rsp_in(rsp), .req_out(req));
  function automatic logic [7:0] ad(logic [4:0] x, int i);
    return 8'((x + i) * 4);
  endfunction
  function automatic logic [31:0] en_def(int i);
    return (i == 0 || i == 4) ? 32'h0 : 32'h0000_FFFF;
  endfunction
  function automatic logic [31:0] cnd(int i);
    return {16'h0000, live_in[i] | ((i == 0 && idle_in) ? 16'h0400 : 16'h0)};
  endfunction
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a);
    i_scseq_host.rd(a, d, r, to);
    if (to) begin err_total++; test_done(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_scseq_host.wr(a, v, r, to);
    if (to) begin err_total++; test_done(); end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CK("rdata", e, d)
  endtask
  task automatic push(input logic signed [15:0] c);
    @(posedge ref_clk_in);
    msg_in <= '{1'b1, c};
    @(posedge ref_clk_in);
    msg_in <= '{1'b0, c};
    if (q.size() < 9) q.push_back(c);
    else if (q.size() == 9) q.push_back(SCSEQ_MSG_OVF);
  endtask
  task automatic pop(input logic [4:0] x);
    logic signed [15:0] e;
    e = q.size() ? q.pop_front() : SCSEQ_MSG_NONE;
    rc(ad(x, 0), {{16{e[15]}}, e});
  endtask
  task automatic defaults();
    for (int i = 0; i < 5; i++)
    begin
      rc(ad(SCSEQ_IDX_RISE, i), 32'h0000_FFFF);
      rc(ad(SCSEQ_IDX_FALL, i), 32'h0);
      rc(ad(SCSEQ_IDX_ENAB, i), en_def(i));
    end
  endtask
  initial
  begin
    live_in = '0;
    idle_in = 1'b1;
    ce_in = 1'b1;
    msg_in = '0;
    err_total = 0;
    compares = 0;
    void'($urandom(91695));
    repeat (3) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    defaults();
    $display("test reset values done");
    for (int j = 0; j < 4; j++)
    begin
      for (int i = 0; i < 5; i++) live_in[i] <= 16'($urandom);
      live_in[0][SCSEQ_IDLE_BIT] <= 1'b0;
      idle_in <= ~j[0];
      repeat (3) @(posedge ref_clk_in);
      for (int i = 0; i < 5; i++) rc(ad(SCSEQ_IDX_COND, i), cnd(i));
      rc(ad(SCSEQ_IDX_COND, 0), cnd(0));
    end
    $display("test condition reads done");
    push(-16'sd113);
    for (int i = 0; i < 15; i++) wr(ad(SCSEQ_IDX_RISE, i), $urandom);
    wr(ad(SCSEQ_IDX_CTRL, 0), 32'h1);
    defaults();
    for (int i = 0; i < 5; i++) rc(ad(SCSEQ_IDX_COND, i), cnd(i));
    rc(ad(SCSEQ_IDX_QCOUNT, 0), 32'h1);
    $display("test preset done");
    for (int i = 0; i < 3; i++) push(16'($urandom));
    for (int i = 0; i < 5; i++) pop(i[0] ? SCSEQ_IDX_SYSERR : SCSEQ_IDX_QUEUE);
    for (int i = 0; i < 12; i++) push(16'($urandom));
    rc(ad(SCSEQ_IDX_QCOUNT, 0), 32'hA);
    for (int i = 0; i < 11; i++) pop(SCSEQ_IDX_QUEUE);
    push(16'sd7);
    push(-16'sd200);
    wr(ad(SCSEQ_IDX_CTRL, 0), 32'h2);
    q.delete();
    rc(ad(SCSEQ_IDX_QCOUNT, 0), 32'h0);
    pop(SCSEQ_IDX_SYSERR);
    // A message pulse during a frozen cycle is not taken
    ce_in <= 1'b0;
    push(16'sd3);
    ce_in <= 1'b1;
    q.delete();
    rc(ad(SCSEQ_IDX_QCOUNT, 0), 32'h0);
    $display("test queue done");
    wr(ad(SCSEQ_IDX_IRQ_MASK, 0), 32'h40);
    wr(ad(SCSEQ_IDX_IRQ_ST, 0), 32'h7F);
    `CK("irq", 1'b0, irq_out)
    push(16'sd5);
    repeat (2) @(posedge ref_clk_in);
    `CK("irq", 1'b1, irq_out)
    wr(ad(SCSEQ_IDX_IRQ_MASK, 0), 32'h0);
    `CK("irq", 1'b0, irq_out)
    wr(ad(SCSEQ_IDX_IRQ_MASK, 0), 32'h40);
    `CK("irq", 1'b1, irq_out)
    pop(SCSEQ_IDX_QUEUE);
    wr(ad(SCSEQ_IDX_IRQ_ST, 0), 32'h40);
    `CK("irq", 1'b0, irq_out)
    rd(8'h80);
    `CK("rresp", SCSEQ_RESP_SLVERR, r)
    `CK("rdata", 32'h0, d)
    $display("test interrupt and unmapped done");
    push(16'sd9);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    q.delete();
    `CK("irq", 1'b0, irq_out)
    rc(ad(SCSEQ_IDX_QCOUNT, 0), 32'h0);
    defaults();
    $display("test second reset done");
    test_done();
  end
endmodule
